/* hdl/ctm_pkg.sv */
// constants, types and register map of the capture and match timer
// ==========================================================
// Operation
// - 32-bit count stepped by the prescale stage
// - 32-bit prescaler triggers the 32-bit count
// - four capture channels latch count on input change
// - match keeps counting, optional interrupt
// - stop-on-match halts counting, optional interrupt
// - reset-on-match returns count to zero
// - match outputs: low, high, toggle or nothing
// - both counters advance on timer clock only
// - bus side and counter side run in one clock domain
// - gated timer branch from one common base
package ctm_pkg;

  // ==========================================================
  // sizes
  localparam int CNT_W = 32;
  localparam int NCH = 4;
  localparam int IDX_W = 5;
  localparam int STAT_W = 2 * NCH;

  // ==========================================================
  // timing: bus clock and timer base clock
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int TMR_BASE_HZ = 10_000_000;
  localparam int TMR_BASE_DIV = REF_CLK_HZ / TMR_BASE_HZ;

  // ==========================================================
  // register word indices, byte address is four times these
  localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_COUNT = 5'h01;
  localparam logic [IDX_W-1:0] IDX_PRE_LIMIT = 5'h02;
  localparam logic [IDX_W-1:0] IDX_PRE_COUNT = 5'h03;
  localparam logic [IDX_W-1:0] IDX_MATCH_CTL = 5'h04;
  localparam logic [IDX_W-1:0] IDX_OUT_CTL = 5'h05;
  localparam logic [IDX_W-1:0] IDX_CAP_CTL = 5'h06;
  localparam logic [IDX_W-1:0] IDX_MATCH0 = 5'h08;
  localparam logic [IDX_W-1:0] IDX_CAPT0 = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_INT_STAT = 5'h10;
  localparam logic [IDX_W-1:0] IDX_INT_MASK = 5'h11;
  localparam int MAP_LEN = 18;

  // ==========================================================
  // fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int OUT_STATE_LSB = 8;
  localparam logic [CNT_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 32'h0000_0001;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } out_act_t;

  typedef struct packed {
    logic int_en;
    logic rst_en;
    logic stop_en;
  } match_ctl_t;

  typedef struct packed {
    logic int_en;
    logic fall_en;
    logic rise_en;
  } cap_ctl_t;

endpackage

/* hdl/tick_branch.sv */
// common base divider and gated branch enable for the timer clock
`timescale 1ns/100ps
module tick_branch #(
  parameter int DIV = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // branch gate and enable pulse
  input wire logic gate_en,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] base_r;
  logic base_wrap;
  logic tick_r;

  // ==========================================================
  // base runs free so every branch shares one phase
  assign base_wrap = (base_r == LAST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_r <= '0;
      tick_r <= 1'b0;
    end else begin
      base_r <= base_wrap ? '0 : base_r + CW'(1);
      tick_r <= base_wrap & gate_en;
    end
  end

  assign tick = tick_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_branch_gated: assert property (!gate_en |=> !tick)
    else $error("timer branch ticked while gated off");
endmodule

/* hdl/capture_match_timer.sv */
// capture and match timer with its bus slave
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module capture_match_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pins
  input wire logic [ctm_pkg::NCH-1:0] snapshot_trigger_in,
  output logic [ctm_pkg::NCH-1:0] compare_event_out,
  // interrupt
  output logic irq
);
  import ctm_pkg::*;

  // ==========================================================
  // bus decode
  logic ap_valid;
  logic wr_pend_r;
  logic [IDX_W-1:0] wr_idx_r;
  logic [MAP_LEN-1:0] wr_sel;
  logic [IDX_W-1:0] ap_idx;
  logic [31:0] rdata_r;

  assign ap_valid = hsel & htrans[1] & hready;
  assign ap_idx = haddr[IDX_W+1:2];

  // single-cycle data phase, only word transfers are expected
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= '0;
    end else begin
      wr_pend_r <= ap_valid & hwrite;
      wr_idx_r <= ap_valid ? ap_idx : wr_idx_r;
    end
  end

  genvar k;
  generate
    for (k = 0; k < MAP_LEN; k++) begin : g_wsel
      assign wr_sel[k] = wr_pend_r & (wr_idx_r == IDX_W'(k));
    end
  endgenerate

  // ==========================================================
  // software registers
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [CNT_W-1:0] pre_limit_r;
  match_ctl_t [NCH-1:0] match_ctl_r;
  logic [2*NCH-1:0] out_ctl_r;
  cap_ctl_t [NCH-1:0] cap_ctl_r;
  logic [CNT_W-1:0] match_r [NCH];
  logic [CNT_W-1:0] capt_r [NCH];
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;

  // ==========================================================
  // counters
  logic tmr_tick;
  logic run;
  logic step;
  logic [CNT_W-1:0] pre_r;
  logic [CNT_W-1:0] pre_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] hit_rst;
  logic [NCH-1:0] hit_stop;
  logic any_rst;
  logic any_stop;

  // branch enable derived from the bus clock, so no second domain exists
  tick_branch #(
    .DIV(TMR_BASE_DIV)
  ) u_branch (
    .ref_clk(ref_clk),
    .rst(rst),
    .gate_en(ctrl_r[CTRL_EN_BIT]),
    .tick(tmr_tick)
  );

  assign run = ctrl_r[CTRL_EN_BIT] & ~ctrl_r[CTRL_CLR_BIT];
  assign step = tmr_tick & run & (pre_r == pre_limit_r);
  assign any_rst = |hit_rst;
  assign any_stop = |hit_stop;

  generate
    for (k = 0; k < NCH; k++) begin : g_hit
      assign hit[k] = step & (count_r == match_r[k]);
      assign hit_rst[k] = hit[k] & match_ctl_r[k].rst_en;
      assign hit_stop[k] = hit[k] & match_ctl_r[k].stop_en;
    end
  endgenerate

  // counters advance only on the timer enable; the clear bit zeroes them on any cycle
  assign pre_nxt = ctrl_r[CTRL_CLR_BIT] ? WORD_ZERO :
                   ~(tmr_tick & run) ? pre_r :
                   (pre_r == pre_limit_r) ? WORD_ZERO : pre_r + COUNT_ONE;
  assign count_nxt = ctrl_r[CTRL_CLR_BIT] ? WORD_ZERO :
                     ~step ? count_r :
                     any_rst ? WORD_ZERO :
                     any_stop ? count_r : count_r + COUNT_ONE;
  // a stop match wins over a software enable write in the same cycle
  assign ctrl_nxt = (wr_sel[IDX_CTRL] ? hwdata[1:0] : ctrl_r) &
                    ~(2'(any_stop) << CTRL_EN_BIT);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_r <= WORD_ZERO;
      count_r <= WORD_ZERO;
      ctrl_r <= CTRL_RST;
    end else begin
      pre_r <= pre_nxt;
      count_r <= count_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // configuration writes, applied on the bus clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_limit_r <= WORD_ZERO;
      match_ctl_r <= '0;
      out_ctl_r <= '0;
      cap_ctl_r <= '0;
      mask_r <= '0;
    end else begin
      if (wr_sel[IDX_PRE_LIMIT]) pre_limit_r <= hwdata;
      if (wr_sel[IDX_MATCH_CTL]) match_ctl_r <= hwdata[3*NCH-1:0];
      if (wr_sel[IDX_OUT_CTL]) out_ctl_r <= hwdata[2*NCH-1:0];
      if (wr_sel[IDX_CAP_CTL]) cap_ctl_r <= hwdata[3*NCH-1:0];
      if (wr_sel[IDX_INT_MASK]) mask_r <= hwdata[STAT_W-1:0];
    end
  end

  // ==========================================================
  // capture inputs, match outputs and match values
  logic [NCH-1:0] sync1_r;
  logic [NCH-1:0] sync2_r;
  logic [NCH-1:0] sync3_r;
  logic [NCH-1:0] cap_evt;
  logic [NCH-1:0] out_r;
  logic [NCH-1:0] out_nxt;

  // pins are asynchronous: two flops before any edge logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      out_r <= '0;
    end else begin
      sync1_r <= snapshot_trigger_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      out_r <= out_nxt;
    end
  end

  generate
    for (k = 0; k < NCH; k++) begin : g_chan
      out_act_t act;
      assign act = out_act_t'(out_ctl_r[2*k+1:2*k]);
      assign cap_evt[k] = (sync2_r[k] & ~sync3_r[k] & cap_ctl_r[k].rise_en) |
                          (~sync2_r[k] & sync3_r[k] & cap_ctl_r[k].fall_en);
      assign out_nxt[k] = ~hit[k] ? out_r[k] :
                          (act == ACT_LOW) ? 1'b0 :
                          (act == ACT_HIGH) ? 1'b1 :
                          (act == ACT_TOGGLE) ? ~out_r[k] : out_r[k];

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          match_r[k] <= WORD_ZERO;
          capt_r[k] <= WORD_ZERO;
        end else begin
          if (wr_sel[IDX_MATCH0 + IDX_W'(k)]) match_r[k] <= hwdata;
          if (cap_evt[k]) capt_r[k] <= count_r;
        end
      end
    end
  endgenerate

  // ==========================================================
  // interrupt status: match bits low, capture bits high
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [NCH-1:0] match_int;
  logic [NCH-1:0] cap_int;
  logic irq_r;

  generate
    for (k = 0; k < NCH; k++) begin : g_int
      assign match_int[k] = hit[k] & match_ctl_r[k].int_en;
      assign cap_int[k] = cap_evt[k] & cap_ctl_r[k].int_en;
    end
  endgenerate

  assign stat_set = {cap_int, match_int};
  assign stat_clr = wr_sel[IDX_INT_STAT] ? hwdata[STAT_W-1:0] : '0;
  // an event in the clearing cycle survives
  assign stat_nxt = (stat_r & ~stat_clr) | stat_set;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ==========================================================
  // read map, unmapped words read zero
  logic [31:0] rd_map [32];

  generate
    for (k = 0; k < 32; k++) begin : g_rmap
      if (k == IDX_CTRL) begin : g_c
        assign rd_map[k] = {30'h0, ctrl_r};
      end else if (k == IDX_COUNT) begin : g_t
        assign rd_map[k] = count_r;
      end else if (k == IDX_PRE_LIMIT) begin : g_pl
        assign rd_map[k] = pre_limit_r;
      end else if (k == IDX_PRE_COUNT) begin : g_pc
        assign rd_map[k] = pre_r;
      end else if (k == IDX_MATCH_CTL) begin : g_mc
        assign rd_map[k] = {20'h0, match_ctl_r};
      end else if (k == IDX_OUT_CTL) begin : g_oc
        assign rd_map[k] = {20'h0, out_r, out_ctl_r};
      end else if (k == IDX_CAP_CTL) begin : g_cc
        assign rd_map[k] = {20'h0, cap_ctl_r};
      end else if (k >= IDX_MATCH0 && k < IDX_MATCH0 + NCH) begin : g_m
        assign rd_map[k] = match_r[k - IDX_MATCH0];
      end else if (k >= IDX_CAPT0 && k < IDX_CAPT0 + NCH) begin : g_cp
        assign rd_map[k] = capt_r[k - IDX_CAPT0];
      end else if (k == IDX_INT_STAT) begin : g_s
        assign rd_map[k] = {24'h0, stat_r};
      end else if (k == IDX_INT_MASK) begin : g_k
        assign rd_map[k] = {24'h0, mask_r};
      end else begin : g_z
        assign rd_map[k] = WORD_ZERO;
      end
    end
  endgenerate

  // read data sampled in the address phase; a write just before is not yet seen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= WORD_ZERO;
    end else if (ap_valid & ~hwrite) begin
      rdata_r <= rd_map[ap_idx];
    end
  end

  logic ready_r;
  logic resp_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end else begin
      ready_r <= 1'b1;
      resp_r <= 1'b0;
    end
  end

  assign hreadyout = ready_r;
  assign hresp = resp_r;
  assign hrdata = rdata_r;
  assign compare_event_out = out_r;
  assign irq = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_prescale_wrap: assert property (step && !ctrl_r[CTRL_CLR_BIT] |=> pre_r == WORD_ZERO)
    else $error("prescaler did not wrap at its limit");
  chk_count_step: assert property (step && !any_rst && !any_stop |=>
    count_r == $past(count_r) + COUNT_ONE)
    else $error("count did not step on prescaler wrap");
  chk_count_only_step: assert property (!step && !ctrl_r[CTRL_CLR_BIT] |=> $stable(count_r))
    else $error("count moved without a prescaler wrap");
  chk_pre_tick_only: assert property (!tmr_tick && !ctrl_r[CTRL_CLR_BIT] |=> $stable(pre_r))
    else $error("prescaler moved without timer enable");
  chk_stop_halts: assert property (any_stop && !any_rst |=>
    !ctrl_r[CTRL_EN_BIT] && count_r == $past(count_r))
    else $error("stop match did not halt the count");
  chk_reset_match: assert property (any_rst && !ctrl_r[CTRL_CLR_BIT] |=> count_r == WORD_ZERO)
    else $error("reset match did not clear the count");
  chk_cont_match: assert property (hit[0] && !any_stop && !wr_sel[IDX_CTRL] |=> run)
    else $error("plain match stopped the timer");
  chk_capture_latch: assert property (cap_evt[0] |=> capt_r[0] == $past(count_r))
    else $error("capture did not latch the count");
  chk_out_toggle: assert property (hit[1] && out_ctl_r[3:2] == ACT_TOGGLE |=>
    compare_event_out[1] != $past(compare_event_out[1]))
    else $error("match output did not toggle");
  chk_cap_sync: assert property (cap_evt[2] |->
    $past(snapshot_trigger_in[2], 2) != $past(snapshot_trigger_in[2], 3))
    else $error("capture without a synchronised pin change");
  chk_irq_level: assert property (|(stat_r & mask_r) |=> irq)
    else $error("interrupt not raised for unmasked status");

  cov_reset_match: cover property (any_rst ##1 step);
  cov_capture: cover property (cap_evt[0] ##[1:20] hit[0]);
  cov_stop: cover property (any_stop);
  cov_clear_race: cover property (wr_sel[IDX_INT_STAT] && |stat_set);
endmodule

/* bench/pin_partner.sv */
// capture pin source standing in for the outside world
`timescale 1ns/100ps
module pin_partner #(
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bench request and driven pins
  input wire logic [ctm_pkg::NCH-1:0] want,
  output logic [ctm_pkg::NCH-1:0] snapshot_trigger_in
);
  import ctm_pkg::*;
  logic [NCH-1:0] dly_r [DLY];
  // ==========================================================
  // pins lag the request, a slow source
  always @(posedge ref_clk) begin
    if (rst) begin
      dly_r <= '{default: '0};
      snapshot_trigger_in <= '0;
    end else begin
      dly_r[0] <= want;
      for (int i = 1; i < DLY; i++) begin
        dly_r[i] <= dly_r[i-1];
      end
      snapshot_trigger_in <= dly_r[DLY-1];
    end
  end
endmodule

/* bench/capture_match_timer_bench.sv */
// self-checking bench for the capture and match timer
`timescale 1ns/100ps
module capture_match_timer_bench;
  import ctm_pkg::*;
  // ==========================================================
  // signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  logic [NCH-1:0] want = '0;
  logic [NCH-1:0] pins;
  logic [NCH-1:0] outs;
  logic [31:0] rd;
  logic [31:0] rd2;
  int error_cnt = 0;
  int checks_done = 0;

  always #12.5 ref_clk = ~ref_clk;

  capture_match_timer i_dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .snapshot_trigger_in(pins), .compare_event_out(outs), .irq(irq)
  );

  pin_partner i_pins (.ref_clk(ref_clk), .rst(rst), .want(want), .snapshot_trigger_in(pins));

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
  endtask

  // one address phase, then one data phase
  task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {25'h0000000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic rdreg(input logic [IDX_W-1:0] idx, output logic [31:0] q);
    bus(idx, 1'b0, 32'h0000_0000, q);
  endtask

  // polls the enable bit instead of trusting a cycle count
  task automatic wait_stop;
    rd = 32'h0000_0001;
    repeat (40) if (rd[CTRL_EN_BIT] === 1'b1) rdreg(IDX_CTRL, rd);
    check("ctrl_stopped", rd, 32'h0000_0000);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset;
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
    check("irq_rst", {31'h0, irq}, 32'h0);
    check("outs_rst", {28'h0, outs}, 32'h0);
    rdreg(IDX_COUNT, rd);
    check("count_rst", rd, WORD_ZERO);
    rdreg(5'h1F, rd);
    check("unmapped", rd, WORD_ZERO);
  endtask

  // gap between the two sampling edges is 160 cycles, ten steps of 16
  task automatic test_prescale;
    wr(IDX_PRE_LIMIT, 32'h0000_0003);
    wr(IDX_CTRL, 32'h0000_0001);
    rdreg(IDX_COUNT, rd);
    repeat (157) @(posedge ref_clk);
    rdreg(IDX_COUNT, rd2);
    check("count_rate", rd2 - rd, 32'h0000_000A);
    rdreg(IDX_PRE_COUNT, rd);
    check("pre_bound", {31'h0, rd <= 32'h3}, 32'h1);
  endtask

  task automatic test_stop;
    wr(IDX_CTRL, 32'h0000_0002);
    wr(IDX_MATCH0, 32'h0000_0005);
    wr(IDX_MATCH_CTL, 32'h0000_0005);
    wr(IDX_INT_MASK, 32'h0000_0001);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_stop();
    repeat (40) @(posedge ref_clk);
    rdreg(IDX_COUNT, rd);
    check("stop_count", rd, 32'h0000_0005);
    rdreg(IDX_INT_STAT, rd);
    check("stop_stat", rd, 32'h0000_0001);
    check("stop_irq", {31'h0, irq}, 32'h1);
    wr(IDX_INT_STAT, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    check("irq_clr", {31'h0, irq}, 32'h0);
  endtask

  task automatic test_rst_match;
    logic [31:0] mx;
    mx = WORD_ZERO;
    wr(IDX_INT_MASK, 32'h0000_0000);
    wr(IDX_MATCH0, 32'h0000_00FF);
    wr(IDX_MATCH0 + 5'h01, 32'h0000_0003);
    wr(IDX_MATCH_CTL, 32'h0000_0030);
    wr(IDX_CTRL, 32'h0000_0002);
    wr(IDX_CTRL, 32'h0000_0001);
    repeat (24) begin
      rdreg(IDX_COUNT, rd);
      if (rd > mx) mx = rd;
    end
    check("wrap_max", mx, 32'h0000_0003);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(IDX_CTRL, 32'h0000_0000);
    rdreg(IDX_PRE_COUNT, rd);
    repeat (20) @(posedge ref_clk);
    rdreg(IDX_PRE_COUNT, rd2);
    check("pre_gated", rd2, rd);
    rdreg(IDX_INT_STAT, rd);
    check("wrap_stat", rd, 32'h0000_0002);
    wr(IDX_INT_STAT, 32'h0000_0002);
    rdreg(IDX_INT_STAT, rd);
    check("stat_w1c", rd, 32'h0000_0000);
  endtask

  // channel i takes action code i: none, low, high, toggle
  task automatic test_outputs;
    wr(IDX_MATCH_CTL, 32'h0000_0001);
    wr(IDX_OUT_CTL, 32'h0000_00E4);
    for (int i = 0; i < NCH; i++) begin
      wr(IDX_MATCH0 + 5'(i), 32'h0000_0002);
    end
    wr(IDX_CTRL, 32'h0000_0002);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_stop();
    check("outs", {28'h0, outs}, 32'h0000_000C);
    rdreg(IDX_OUT_CTL, rd);
    check("out_state", rd, 32'h0000_0CE4);
    // second pass from the new levels: high, toggle, none, low
    wr(IDX_OUT_CTL, 32'h0000_004E);
    wr(IDX_CTRL, 32'h0000_0002);
    wr(IDX_CTRL, 32'h0000_0001);
    wait_stop();
    check("outs_2", {28'h0, outs}, 32'h0000_0007);
    rdreg(IDX_OUT_CTL, rd);
    check("out_state_2", rd, 32'h0000_074E);
  endtask

  // counter stays stopped at 2, captures still run
  task automatic test_capture;
    wr(IDX_CAP_CTL, 32'h0000_0146);
    wr(IDX_INT_MASK, 32'h0000_0040);
    want <= 4'h4;
    repeat (12) @(posedge ref_clk);
    rdreg(IDX_CAPT0 + 5'h02, rd);
    check("capt2", rd, 32'h0000_0002);
    rdreg(IDX_INT_STAT, rd);
    check("cap_stat", rd, 32'h0000_0040);
    check("cap_irq", {31'h0, irq}, 32'h1);
    want <= 4'h5;
    repeat (12) @(posedge ref_clk);
    rdreg(IDX_INT_STAT, rd);
    check("no_rise0", rd, 32'h0000_0040);
    want <= 4'h4;
    repeat (12) @(posedge ref_clk);
    rdreg(IDX_INT_STAT, rd);
    check("fall0", rd, 32'h0000_0050);
    rdreg(IDX_CAPT0, rd);
    check("capt0", rd, 32'h0000_0002);
  endtask

  // ==========================================================
  // run and watchdog
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_prescale();
    test_stop();
    test_rst_match();
    test_outputs();
    test_capture();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule
